// ---- prx_consts.svh ----
// constants for the proximity measurement and interrupt block
// assumes it is included by bare name into every file that needs offsets or counts
//
// Notes on behaviour
// R1 - subtract cancellation offset before storing result
// R2 - offset is 11 bits over two registers
// R3 - enable write powers up support blocks
// R4 - wait settle time, then convert at rate
// R5 - disable finishes running conversion, then powers down
// R6 - interrupt evaluated only after each conversion
// R7 - interrupt pin is low when active
// R8 - out-of-window for persist count raises interrupt
// R9 - near/far bit: below clears, above sets
// R10 - pin is level follower or latched event
// R11 - status interrupt flag cleared by status read
// R12 - control resets to standby, 0x01 measures
// R13 - led drive setting resets to 0x36
// R14 - pulse count up to 32, reset eight
// R15 - resolution and rate resets to 0x45
// R16 - persistence needs field plus one results
// R17 - result low byte, high bits, overflow bit
// R18 - thresholds 11 bits, upper all ones
// R19 - config bit 1 selects pin behaviour
// R20 - negative difference clamps result to zero
// R21 - persistence counter clears in window or disabled
`ifndef PRX_CONSTS_SVH
`define PRX_CONSTS_SVH

// ==================================================
// register offsets
`define PRX_A_CTRL        8'h00
`define PRX_A_LED         8'h01
`define PRX_A_PULSES      8'h02
`define PRX_A_RATE        8'h03
`define PRX_A_STATUS      8'h07
`define PRX_A_DATA_LO     8'h08
`define PRX_A_DATA_HI     8'h09
`define PRX_A_INT_CFG     8'h19
`define PRX_A_PERSIST     8'h1a
`define PRX_A_UP_LO       8'h1b
`define PRX_A_UP_HI       8'h1c
`define PRX_A_LOW_LO      8'h1d
`define PRX_A_LOW_HI      8'h1e
`define PRX_A_CAN_LO      8'h1f
`define PRX_A_CAN_HI      8'h20

// ==================================================
// reset values and field positions
`define PRX_RST_CTRL      8'h00
`define PRX_RST_LED       8'h36
`define PRX_RST_PULSES    8'h08
`define PRX_MAX_PULSES    8'h20
`define PRX_RST_RATE      8'h45
`define PRX_RST_INT_CFG   2'h0
`define PRX_INT_CFG_FIXED 8'h10
`define PRX_RST_UP        11'h7ff
`define PRX_RST_LOW       11'h000
`define PRX_ST_NEW        0
`define PRX_ST_IRQ        1
`define PRX_ST_NEAR       2
`define PRX_ST_PWR        5
`define PRX_RATE_REF_CODE 3'h5

// ==================================================
// timing
`define PRX_CLK_KHZ       40000
`define PRX_SETTLE_US     5000
`define PRX_SETTLE_CYC    ((`PRX_SETTLE_US * `PRX_CLK_KHZ) / 1000)
`define PRX_RATE_REF_MS   100
`define PRX_RATE_REF_CYC  (`PRX_RATE_REF_MS * `PRX_CLK_KHZ)

`endif

// ---- prx_pkg.sv ----
// types shared by the proximity block
// assumes nothing beyond a SystemVerilog compiler
package prx_pkg;

    // ==================================================
    // measurement sequencer states
    typedef enum logic [1:0] {
        PRX_IDLE   = 2'b00,
        PRX_SETTLE = 2'b01,
        PRX_WAIT   = 2'b10,
        PRX_CONV   = 2'b11
    } prx_state_t;

endpackage

// ---- prx_eval_if.sv ----
// carrier between the sequencer and the threshold evaluator
// assumes both ends run on the one block clock
`timescale 1ns/1ps
`default_nettype none
interface prx_eval_if;
    logic        valid;
    logic [10:0] result;
    logic [10:0] thr_up;
    logic [10:0] thr_low;
    logic [3:0]  persist;
    logic        irq_enable;
    logic        clear;
    logic        trigger;
    logic        near_far;

    modport seq  (output valid, result, thr_up, thr_low, persist, irq_enable, clear,
                  input trigger, near_far);
    modport eval (input valid, result, thr_up, thr_low, persist, irq_enable, clear,
                  output trigger, near_far);
endinterface
`default_nettype wire

// ---- prx_eval.sv ----
// threshold compare, persistence count and near/far state
// assumes valid is a one-cycle pulse per stored result
`timescale 1ns/1ps
`default_nettype none
`include "prx_consts.svh"
module prx_eval
    import prx_pkg::*;
(
    // clock and reset
    input  wire logic clock,
    input  wire logic sys_rst,
    // link to the sequencer
    prx_eval_if.eval  ev
);
    logic [3:0] persistence_count;
    logic       above;
    logic       below;

    assign above = ev.result > ev.thr_up;
    assign below = ev.result < ev.thr_low;

    // ==================================================
    // persistence count and trigger on a fresh result; clear zeroes the count at any time
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            persistence_count <= 4'h0;
            ev.trigger        <= 1'b0;
        end
        else
        begin
            ev.trigger <= 1'b0;
            if (ev.clear)
                persistence_count <= 4'h0;                      // R21
            else if (ev.valid)                                  // R6
            begin
                if (!(above || below))
                    persistence_count <= 4'h0;                  // R21
                else if (persistence_count >= ev.persist)       // R16
                begin
                    persistence_count <= 4'h0;                  // restart so a long run repeats
                    ev.trigger        <= ev.irq_enable;         // R8
                end
                else
                    persistence_count <= persistence_count + 4'h1;
            end
        end
    end

    // ==================================================
    // near/far level holds between results
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            ev.near_far <= 1'b0;
        else if (ev.valid && below)
            ev.near_far <= 1'b0;                                // R9
        else if (ev.valid && above)
            ev.near_far <= 1'b1;                                // R9
    end

    // ==================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    AST_EVAL_ONLY_ON_RESULT: assert property (!ev.valid |=> $stable(ev.near_far)) // R6
        else $error("near/far changed without a new result");
    AST_NEAR_SET: assert property (ev.valid && above |=> ev.near_far) // R9
        else $error("near/far not set above upper threshold");
    AST_FAR_CLEAR: assert property (ev.valid && below |=> !ev.near_far) // R9
        else $error("near/far not cleared below lower threshold");
    AST_WINDOW_RESETS_COUNT: assert property (ev.valid && !above && !below |=> persistence_count == 4'h0) // R21
        else $error("persistence count kept inside window");
    AST_PERSIST_ZERO: assert property (ev.valid && !ev.clear && (above || below) && ev.persist == 4'h0
                                       && ev.irq_enable |=> ev.trigger) // R16
        else $error("persist zero did not interrupt on first result");
endmodule
`default_nettype wire

// ---- prx_measure_top.sv ----
// proximity measurement sequencer, byte registers and interrupt pin
// assumes a byte register port from an external serial slave engine and an
// analog converter front end on the same clock, so neither is synchronised
`timescale 1ns/1ps
`default_nettype none
`include "prx_consts.svh"
module prx_measure_top
    import prx_pkg::*;
#(
    parameter logic [31:0] SETTLE_CYC   = `PRX_SETTLE_CYC,
    parameter logic [31:0] RATE_REF_CYC = `PRX_RATE_REF_CYC
)
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // byte register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // converter front end
    output logic             support_power_on,
    output logic             conv_start,
    input  wire logic        conv_done,
    input  wire logic [10:0] conv_raw,
    input  wire logic        conv_overflow,
    output logic      [1:0]  conv_resolution,
    // led driver settings
    output logic      [7:0]  led_drive_setting,
    output logic      [7:0]  led_pulse_count,
    // interrupt pin, active low
    output logic             int_n
);
    prx_state_t  state;
    logic [7:0]  operating_mode_control;
    logic [7:0]  resolution_and_rate;
    logic [1:0]  int_cfg;
    logic [3:0]  interrupt_persistence;
    logic [10:0] prox_threshold_up;
    logic [10:0] prox_threshold_low;
    logic [10:0] offset_cancel;
    logic [10:0] prox_result;
    logic        result_overflow;
    logic        new_data;
    logic        prox_irq_flag;
    logic        power_on_flag;
    logic        irq_latched;
    logic        result_new;
    logic [31:0] settle_cnt;
    logic [31:0] rate_cnt;
    logic [31:0] rate_period;
    logic        measure_enable;
    logic        prox_irq_enable;
    logic        pin_behaviour_select;
    logic        rate_hit;
    logic        store;
    logic        status_read;
    logic [10:0] next_result;
    logic [7:0]  next_rdata;

    prx_eval_if  ev_link();

    assign measure_enable       = operating_mode_control[0];
    assign prox_irq_enable      = int_cfg[0];
    assign pin_behaviour_select = int_cfg[1];
    assign conv_resolution      = resolution_and_rate[4:3];
    assign status_read          = reg_rd && (reg_addr == `PRX_A_STATUS);
    assign store                = (state == PRX_CONV) && conv_done;

    // ==================================================
    // repeat period scales by powers of two around the reference code
    always_comb
    begin
        if (resolution_and_rate[2:0] >= `PRX_RATE_REF_CODE)
            rate_period = RATE_REF_CYC << (resolution_and_rate[2:0] - `PRX_RATE_REF_CODE);
        else
            rate_period = RATE_REF_CYC >> (`PRX_RATE_REF_CODE - resolution_and_rate[2:0]);
    end
    assign rate_hit = rate_cnt >= (rate_period - 32'h1);

    // ==================================================
    // register writes
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            operating_mode_control <= `PRX_RST_CTRL;              // R12
            led_drive_setting      <= `PRX_RST_LED;               // R13
            led_pulse_count        <= `PRX_RST_PULSES;            // R14
            resolution_and_rate    <= `PRX_RST_RATE;              // R15
            int_cfg                <= `PRX_RST_INT_CFG;           // R19
            interrupt_persistence  <= 4'h0;
            prox_threshold_up      <= `PRX_RST_UP;                // R18
            prox_threshold_low     <= `PRX_RST_LOW;               // R18
            offset_cancel          <= 11'h000;                    // R2
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `PRX_A_CTRL:    operating_mode_control <= {7'h00, reg_wdata[0]}; // R3 R12
                `PRX_A_LED:     led_drive_setting      <= reg_wdata;             // R13
                `PRX_A_PULSES:  led_pulse_count        <= (reg_wdata > `PRX_MAX_PULSES) ?
                                                          `PRX_MAX_PULSES : reg_wdata; // R14
                `PRX_A_RATE:    resolution_and_rate    <= reg_wdata;             // R15
                `PRX_A_INT_CFG: int_cfg                <= reg_wdata[1:0];        // R19
                `PRX_A_PERSIST: interrupt_persistence  <= reg_wdata[3:0];        // R16
                `PRX_A_UP_LO:   prox_threshold_up[7:0]   <= reg_wdata;           // R18
                `PRX_A_UP_HI:   prox_threshold_up[10:8]  <= reg_wdata[2:0];      // R18
                `PRX_A_LOW_LO:  prox_threshold_low[7:0]  <= reg_wdata;           // R18
                `PRX_A_LOW_HI:  prox_threshold_low[10:8] <= reg_wdata[2:0];      // R18
                `PRX_A_CAN_LO:  offset_cancel[7:0]       <= reg_wdata;           // R2
                `PRX_A_CAN_HI:  offset_cancel[10:8]      <= reg_wdata[2:0];      // R2
                default:        ;
            endcase
        end
    end

    // ==================================================
    // read mux; reserved bits read zero except INT_CFG bit 4, which reads one; unmapped offsets read zero
    always_comb
    begin
        case (reg_addr)
            `PRX_A_CTRL:    next_rdata = operating_mode_control;
            `PRX_A_LED:     next_rdata = led_drive_setting;
            `PRX_A_PULSES:  next_rdata = led_pulse_count;
            `PRX_A_RATE:    next_rdata = resolution_and_rate;
            `PRX_A_STATUS:  next_rdata = {2'b00, power_on_flag, 2'b00, ev_link.near_far,
                                          prox_irq_flag, new_data};
            `PRX_A_DATA_LO: next_rdata = prox_result[7:0];
            `PRX_A_DATA_HI: next_rdata = {4'h0, result_overflow, prox_result[10:8]}; // R17
            `PRX_A_INT_CFG: next_rdata = `PRX_INT_CFG_FIXED | {6'h00, int_cfg};
            `PRX_A_PERSIST: next_rdata = {4'h0, interrupt_persistence};
            `PRX_A_UP_LO:   next_rdata = prox_threshold_up[7:0];
            `PRX_A_UP_HI:   next_rdata = {5'h00, prox_threshold_up[10:8]};
            `PRX_A_LOW_LO:  next_rdata = prox_threshold_low[7:0];
            `PRX_A_LOW_HI:  next_rdata = {5'h00, prox_threshold_low[10:8]};
            `PRX_A_CAN_LO:  next_rdata = offset_cancel[7:0];
            `PRX_A_CAN_HI:  next_rdata = {5'h00, offset_cancel[10:8]};   // R2
            default:        next_rdata = 8'h00;
        endcase
    end

    // read data is captured so it is stable while the slave engine shifts it out
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= next_rdata;
    end

    // ==================================================
    // measurement sequencer
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state      <= PRX_IDLE;
            settle_cnt <= 32'h0;
            rate_cnt   <= 32'h0;
        end
        else
        begin
            case (state)
                PRX_IDLE:
                begin
                    settle_cnt <= 32'h0;
                    if (measure_enable)
                        state <= PRX_SETTLE;                              // R3
                end
                PRX_SETTLE:
                begin
                    if (!measure_enable)
                        state <= PRX_IDLE;
                    else if (settle_cnt >= SETTLE_CYC - 32'h1)            // R4
                    begin
                        state    <= PRX_WAIT;
                        rate_cnt <= rate_period - 32'h1;                  // first conversion at once
                    end
                    else
                        settle_cnt <= settle_cnt + 32'h1;
                end
                PRX_WAIT:
                begin
                    if (!measure_enable)
                        state <= PRX_IDLE;                                // R5
                    else if (rate_hit)
                    begin
                        state    <= PRX_CONV;                             // R4
                        rate_cnt <= 32'h0;
                    end
                    else
                        rate_cnt <= rate_cnt + 32'h1;
                end
                PRX_CONV:
                begin
                    // the period keeps counting so the cadence ignores conversion time
                    rate_cnt <= rate_cnt + 32'h1;
                    if (conv_done)
                        state <= measure_enable ? PRX_WAIT : PRX_IDLE;    // R5
                end
                default: state <= PRX_IDLE;
            endcase
        end
    end

    assign conv_start       = (state == PRX_WAIT) && measure_enable && rate_hit; // R4
    assign support_power_on = (state != PRX_IDLE);                               // R3 R5

    // ==================================================
    // offset cancellation, clamped at zero
    always_comb
    begin
        if (offset_cancel > conv_raw)
            next_result = 11'h000;                                        // R20
        else
            next_result = conv_raw - offset_cancel;                       // R1
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            prox_result     <= 11'h000;
            result_overflow <= 1'b0;
            result_new      <= 1'b0;
        end
        else
        begin
            result_new <= store;
            if (store)
            begin
                prox_result     <= next_result;                           // R1 R17
                result_overflow <= conv_overflow;                         // R17
            end
        end
    end

    // ==================================================
    // threshold evaluator
    assign ev_link.valid      = result_new;                               // R6
    assign ev_link.result     = prox_result;
    assign ev_link.thr_up     = prox_threshold_up;
    assign ev_link.thr_low    = prox_threshold_low;
    assign ev_link.persist    = interrupt_persistence;
    assign ev_link.irq_enable = prox_irq_enable;
    assign ev_link.clear      = (state == PRX_IDLE);                      // R21

    prx_eval u_eval (
        .clock   (clock),
        .sys_rst (sys_rst),
        .ev      (ev_link.eval)
    );

    // ==================================================
    // status flags; a set in the same cycle as the clearing read wins
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            new_data      <= 1'b0;
            prox_irq_flag <= 1'b0;
            power_on_flag <= 1'b1;
            irq_latched   <= 1'b0;
        end
        else
        begin
            if (result_new)
                new_data <= 1'b1;
            else if (status_read)
                new_data <= 1'b0;
            if (ev_link.trigger)
                prox_irq_flag <= 1'b1;                                    // R11
            else if (status_read)
                prox_irq_flag <= 1'b0;                                    // R11
            if (status_read)
                power_on_flag <= 1'b0;
            if (ev_link.trigger)
                irq_latched <= 1'b1;                                      // R10
            else if (status_read)
                irq_latched <= 1'b0;                                      // R10
        end
    end

    // ==================================================
    // interrupt pin; in level mode it tracks near/far, which only moves after a result
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            int_n <= 1'b1;
        else if (!prox_irq_enable)
            int_n <= 1'b1;                                                // R7
        else if (pin_behaviour_select)
            int_n <= !ev_link.near_far;                                   // R7 R10 R19
        else
            int_n <= !(irq_latched || ev_link.trigger);                   // R7 R10 R19
    end

    // ==================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence s_conv_launch;
        (state == PRX_WAIT) && measure_enable && rate_hit ##1 (state == PRX_CONV);
    endsequence

    sequence s_conv_finish;
        (state == PRX_CONV) && conv_done ##1 result_new ##1 !result_new;
    endsequence

    AST_STORE_SUBTRACTS: assert property (store |=> prox_result ==
            (($past(offset_cancel) > $past(conv_raw)) ? 11'h000 : $past(conv_raw) - $past(offset_cancel))) // R1
        else $error("stored result is not raw minus offset");
    AST_NO_EARLY_CONV: assert property ((state == PRX_SETTLE) |-> !conv_start) // R4
        else $error("conversion started during settling");
    AST_SETTLE_LENGTH: assert property ((state == PRX_SETTLE) && (settle_cnt < SETTLE_CYC - 32'h1)
                                        |=> state != PRX_WAIT) // R4
        else $error("settling cut short");
    AST_LAUNCH_CONV: assert property (conv_start |-> s_conv_launch) // R4
        else $error("conversion start not followed by conversion");
    AST_FINISH_RUNNING: assert property ((state == PRX_CONV) && !conv_done |=> state == PRX_CONV) // R5
        else $error("running conversion abandoned");
    AST_POWER_FOLLOWS_STATE: assert property ((state == PRX_CONV) && conv_done && !measure_enable
                                              |=> !support_power_on) // R5
        else $error("support blocks left on after disable");
    AST_RESULT_EVALUATED: assert property (store |-> s_conv_finish) // R6
        else $error("result not handed to evaluator");
    AST_FLAG_CLEARED: assert property (status_read && !ev_link.trigger |=> !prox_irq_flag) // R11
        else $error("interrupt flag survived status read");
    AST_FLAG_SET_WINS: assert property (ev_link.trigger |=> prox_irq_flag) // R11
        else $error("interrupt event lost");
    AST_LATCHED_PIN: assert property (prox_irq_enable && !pin_behaviour_select && ev_link.trigger
                                      && !int_cfg[1] |=> !int_n ##1 (!int_n || $past(status_read))) // R7 R10
        else $error("latched pin released without status read");
    AST_PIN_IDLE_HIGH: assert property (!prox_irq_enable |=> int_n) // R7
        else $error("pin active with interrupt disabled");
endmodule
`default_nettype wire

// ---- prx_front_model.sv ----
// converter front end stand-in: answers each conv_start with one conv_done
// assumes the block clock and at most one conversion in flight
`timescale 1ns/1ps
`default_nettype none
module prx_front_model #(parameter int LAT = 6)
(
    // block clock
    input  wire logic        clock,
    // request and value to return
    input  wire logic        conv_start,
    input  wire logic [10:0] raw_in,
    // answer
    output logic             conv_done,
    output logic      [10:0] conv_raw,
    output logic             conv_overflow
);
    // ==================================================
    // conversion answer
    // result only valid in the done cycle; inverted elsewhere so a stale read shows
    initial
    begin
        conv_done = 1'b0;
        conv_raw = 11'h000;
        conv_overflow = 1'b1;
    end
    always
    begin
        @(posedge clock iff conv_start);
        repeat (LAT) @(posedge clock);
        #1 conv_done = 1'b1;
        conv_raw = raw_in;
        conv_overflow = 1'b0;
        @(posedge clock) #1 conv_done = 1'b0;
        conv_raw = ~raw_in;
        conv_overflow = 1'b1;
    end
endmodule
`default_nettype wire

// ---- proximity_measure_and_interrupt_tb.sv ----
// self-checking bench for prx_measure_top through its byte register port
// assumes short settle and rate counts and prx_front_model as converter
`timescale 1ns/1ps
`default_nettype none
module proximity_measure_and_interrupt_tb;
    logic        clock = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        conv_done, conv_ov, power, start, int_n;
    logic [1:0]  res;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, rdata, led_d, led_p;
    logic [10:0] raw = 11'h200, conv_raw;
    int          n_mismatch = 0, n_checks = 0, k;

    always #12.5 clock = ~clock;
    prx_measure_top #(.SETTLE_CYC(32'h14), .RATE_REF_CYC(32'h40)) dut_u (
        .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .support_power_on(power),
        .conv_start(start), .conv_done(conv_done), .conv_raw(conv_raw), .conv_overflow(conv_ov),
        .conv_resolution(res), .led_drive_setting(led_d), .led_pulse_count(led_p), .int_n(int_n));
    prx_front_model fe_u (.clock(clock), .conv_start(start), .raw_in(raw),
        .conv_done(conv_done), .conv_raw(conv_raw), .conv_overflow(conv_ov));

    // ==================================================
    // access tasks
    task summarize();
        if (n_mismatch == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock) #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clock) #1;
        reg_wr = 1'b0;
    endtask
    // mask lets one status read look at chosen flags only
    task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
        @(posedge clock) #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clock) #1;
        reg_rd = 1'b0;
        chk($sformatf("reg_%h", a), rdata & m, e);
    endtask
    // bounded wait for n results, then time for the pin to follow
    task conv(input int n);
        for (k = 0; k < 2000 && n > 0; k++)
        begin
            @(posedge clock);
            if (conv_done === 1'b1)
                n--;
        end
        if (n > 0)
            chk("conv_timeout", 8'h01, 8'h00);
        if (n > 0)
            summarize();
        repeat (4) @(posedge clock) #1;
    endtask
    task wstart();
        for (k = 0; k < 200 && start !== 1'b1; k++)
            @(posedge clock) #1;
        if (k == 200)
        begin
            chk("start_timeout", 8'h01, 8'h00);
            summarize();
        end
    endtask

    // ==================================================
    // main sequence
    initial
    begin
        repeat (20) @(posedge clock);
        #1 sys_rst = 1'b0;
        rd(8'h00, 8'h00);
        rd(8'h01, 8'h36);
        rd(8'h02, 8'h08);
        rd(8'h03, 8'h45);
        chk("led", led_d, 8'h36);
        chk("res", {6'h00, res}, 8'h00);
        wr(8'h01, 8'h77);
        chk("led", led_d, 8'h77);
        wr(8'h03, 8'h5d);
        chk("res", {6'h00, res}, 8'h03);
        rd(8'h1c, 8'h07);
        rd(8'h1f, 8'h00);
        rd(8'h30, 8'h00);
        wr(8'h20, 8'hff);
        rd(8'h20, 8'h07);
        wr(8'h02, 8'h40);
        rd(8'h02, 8'h20);
        chk("pulses", led_p, 8'h20);
        // offset 0x105, upper 0x010, two results needed, latched pin
        wr(8'h20, 8'h01);
        wr(8'h1f, 8'h05);
        wr(8'h1b, 8'h10);
        wr(8'h1c, 8'h00);
        wr(8'h1a, 8'h01);
        wr(8'h19, 8'h01);
        wr(8'h00, 8'h01);
        // the sequencer leaves idle one edge after the enable write lands
        @(posedge clock) #1;
        chk("power", {7'h00, power}, 8'h01);
        wstart();
        chk("settle", {7'h00, k >= 20 && k <= 22}, 8'h01);
        conv(1);
        chk("int_n", {7'h00, int_n}, 8'h01);
        conv(1);
        chk("int_n", {7'h00, int_n}, 8'h00);
        rd(8'h08, 8'hfb);
        rd(8'h09, 8'h00);
        rd(8'h07, 8'h06, 8'h06);
        // the registered pin releases one edge after the clearing read
        @(posedge clock) #1;
        chk("int_n", {7'h00, int_n}, 8'h01);
        rd(8'h07, 8'h00, 8'h02);
        // level pin follows near/far; a result under the offset clamps to zero
        wr(8'h1d, 8'h20);
        wr(8'h19, 8'h03);
        conv(1);
        chk("int_n", {7'h00, int_n}, 8'h00);
        raw = 11'h010;
        conv(1);
        chk("int_n", {7'h00, int_n}, 8'h01);
        rd(8'h08, 8'h00);
        rd(8'h07, 8'h00, 8'h04);
        // disable in mid-conversion still finishes it
        wstart();
        wr(8'h00, 8'h00);
        chk("power", {7'h00, power}, 8'h01);
        conv(1);
        chk("power", {7'h00, power}, 8'h00);
        summarize();
    end
endmodule
`default_nettype wire
